// ---- inc/evt_counter_pkg.sv ----
// constants and types shared by the event counter channel
`default_nettype none
package evt_counter_pkg;
	localparam int CNT_W = 16;
	localparam logic [15:0] CNT_MAX = 16'hFFFF;
	localparam logic [15:0] CNT_ZERO = 16'h0000;
	localparam logic [15:0] CNT_ONE = 16'h0001;
	localparam logic [15:0] COUNT_RST = 16'h0000;
	localparam logic [15:0] RELOAD_RST = 16'h0000;
	// event source select codes
	localparam logic [1:0] SRC_PIN = 2'h0;
	localparam logic [1:0] SRC_TB2 = 2'h1;
	localparam logic [1:0] SRC_PREV = 2'h2;
	localparam logic [1:0] SRC_NEXT = 2'h3;
	// channel numbering of the timer A group
	localparam logic [2:0] CH_FIRST = 3'h0;
	localparam logic [2:0] CH_LAST = 3'h4;
	localparam logic [2:0] CH_STEP = 3'h1;
	localparam logic [2:0] CH_QUAD_NORMAL = 3'h2;
	localparam logic [2:0] CH_QUAD_SELECT = 3'h3;
	localparam logic [2:0] CH_QUAD_X4 = 3'h4;
	localparam int NUM_CH = 5;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_ARMED = 3'b010,
		ST_RUN = 3'b100
	} run_state_t;
endpackage
`default_nettype wire

// ---- rtl/pin_sync_edge.sv ----
// two-stage pin synchroniser with edge detection
`timescale 1ns/1ps
`default_nettype none
module pin_sync_edge (
	input wire logic i_core_clk,
	input wire logic i_sys_rst,
	input wire logic i_pin,
	output logic o_level,
	output logic o_rise,
	output logic o_fall
);
	typedef struct packed {
		logic meta;
		logic level;
		logic prev;
		logic [2:0] warm;
	} sync_state_t;

	sync_state_t st_q;
	sync_state_t st_d;

	// meta feeds only the second stage; edges compare the settled stages
	always_comb begin
		st_d = st_q;
		st_d.meta = i_pin;
		st_d.level = st_q.meta;
		st_d.prev = st_q.level;
		// edges masked until prev holds a real sample: an idle-high pin gives no false edge
		st_d.warm = {st_q.warm[1:0], 1'b1};
	end

	always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign o_level = st_q.level;
	assign o_rise = st_q.warm[2] & st_q.level & ~st_q.prev;
	assign o_fall = st_q.warm[2] & ~st_q.level & st_q.prev;
endmodule // pin_sync_edge
`default_nettype wire

// ---- rtl/quad_step_decode.sv ----
// two-phase decoder: turns synchronised edges into up or down steps
`timescale 1ns/1ps
`default_nettype none
module quad_step_decode (
	input wire logic i_x4,
	input wire logic i_a_level,
	input wire logic i_a_rise,
	input wire logic i_a_fall,
	input wire logic i_b_level,
	input wire logic i_b_rise,
	input wire logic i_b_fall,
	output logic o_up,
	output logic o_down
);
	logic up_raw;
	logic down_raw;

	always_comb begin
		if (i_x4) begin
			up_raw = (i_a_rise & i_b_level) | (i_b_fall & i_a_level) | (i_a_fall & ~i_b_level) | (i_b_rise & ~i_a_level);
			down_raw = (i_a_fall & i_b_level) | (i_b_rise & i_a_level) | (i_a_rise & ~i_b_level) | (i_b_fall & ~i_a_level);
		end else begin
			up_raw = i_a_rise & i_b_level;
			down_raw = i_a_fall & i_b_level;
		end
	end

	// in x4, both pins moving in one sample is a lost phase; count nothing
	assign o_up = up_raw & ~down_raw;
	assign o_down = down_raw & ~up_raw;
endmodule // quad_step_decode
`default_nettype wire

// ---- rtl/evt_counter_channel.sv ----
// one 16-bit event counter channel with two-phase decoding and index clear
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// (RL1) count events come from a chosen input pin edge, B2, or neighbour wraps
// (RL2) following neighbour is i+1 with 4 wrapping to 0; preceding i-1, 0 to 4
// (RL3) out pin as direction input: low counts down, high up; or program bit
// (RL4) reload mode: each wrap loads the reload value and counting goes on
// (RL5) free-run: wraps pass through without loading the reload value
// (RL6) period for value n is FFFFh-n+1 events up, n+1 events down
// (RL7) start bit 1 starts counting, start bit 0 stops it
// (RL8) every overflow or underflow raises the interrupt request
// (RL9) reading the count register gives the live counter
// (RL10) writes before the first event after start load counter and reload
// (RL11) writes after the first event load only reload; counter takes it on reload
// (RL12) pulse output toggles on each wrap, low while the start bit is 0
// (RL13) pin edges count only when the source select equals 00b
// (RL14) channels 2, 3 and 4 decode two-phase signals on both pins
// (RL15) normal two-phase: in rising up, in falling down, only while out is high
// (RL16) x4: every edge of both pins counts, direction from the phase relation
// (RL17) channel 3 selects normal or x4; channel 2 fixed normal, 4 fixed x4
// (RL18) software enables two-phase, selects source 00b, sets both pins as inputs
// (RL19) on channel 3 the index input clears the counter to zero
// (RL20) index clear only on channel 3, free-run x4 two-phase, enable bit set
// (RL21) the clear after an index edge takes effect at the next count event
// (RL22) a flag set by the first event after start, cleared at stop, routes writes
// (RL23) two-phase pins are synchronised and edge-detected; one step per transition
module evt_counter_channel
#(
	parameter logic [2:0] CHANNEL = 3'h3
) (
	input wire logic i_core_clk,
	input wire logic i_sys_rst,
	input wire logic i_timer_input_pin,
	input wire logic i_timer_out_pin,
	input wire logic i_index_pin,
	input wire logic i_count_start_bit,
	input wire logic [1:0] i_event_source_sel,
	input wire logic i_count_rising_edge,
	input wire logic i_dir_from_pin,
	input wire logic i_direction_flag_reg,
	input wire logic i_free_run,
	input wire logic i_pulse_out_en,
	input wire logic i_two_phase_enable,
	input wire logic i_quad_processing_select,
	input wire logic i_index_clear_enable,
	input wire logic i_index_rising_edge,
	input wire logic i_tb2_wrap,
	input wire logic [evt_counter_pkg::NUM_CH-1:0] i_ta_wrap,
	input wire logic i_count_wr,
	input wire logic [evt_counter_pkg::CNT_W-1:0] i_count_wr_data,
	output logic [evt_counter_pkg::CNT_W-1:0] o_count_register,
	output logic [evt_counter_pkg::CNT_W-1:0] o_reload_value,
	output logic o_wrap_irq,
	output logic o_first_event_seen,
	output logic o_timer_out_pin,
	output logic o_timer_out_pin_oe
);
	import evt_counter_pkg::*;

	typedef struct packed {
		run_state_t phase;
		logic [CNT_W-1:0] count;
		logic [CNT_W-1:0] reload;
		logic irq;
		logic toggle;
		logic out_oe;
		logic index_pend;
	} chan_state_t;

	chan_state_t st_q;
	chan_state_t st_d;

	function automatic logic [2:0] prev_ch(input logic [2:0] ch);
		prev_ch = (ch == CH_FIRST) ? CH_LAST : 3'(ch - CH_STEP);
	endfunction

	function automatic logic [2:0] next_ch(input logic [2:0] ch);
		next_ch = (ch == CH_LAST) ? CH_FIRST : 3'(ch + CH_STEP);
	endfunction

	logic in_level;
	logic in_rise;
	logic in_fall;
	logic out_level;
	logic out_rise;
	logic out_fall;
	logic idx_rise;
	logic idx_fall;
	logic q_up;
	logic q_down;
	logic quad_chan;
	logic quad_x4;
	logic quad_on;
	logic src_event;
	logic ev;
	logic up;
	logic at_limit;
	logic [CNT_W-1:0] stepped;
	logic idx_ok;
	logic idx_edge;
	logic idx_apply;
	logic wr_load;
	logic wrap_evt;

	pin_sync_edge u_in_sync (
		.i_core_clk(i_core_clk),
		.i_sys_rst(i_sys_rst),
		.i_pin(i_timer_input_pin),
		.o_level(in_level),
		.o_rise(in_rise),
		.o_fall(in_fall)
	);

	pin_sync_edge u_out_sync (
		.i_core_clk(i_core_clk),
		.i_sys_rst(i_sys_rst),
		.i_pin(i_timer_out_pin),
		.o_level(out_level),
		.o_rise(out_rise),
		.o_fall(out_fall)
	);

	pin_sync_edge u_idx_sync (
		.i_core_clk(i_core_clk),
		.i_sys_rst(i_sys_rst),
		.i_pin(i_index_pin),
		.o_level(),
		.o_rise(idx_rise),
		.o_fall(idx_fall)
	);

	// see (RL14) see (RL17)
	assign quad_chan = (CHANNEL == CH_QUAD_NORMAL) || (CHANNEL == CH_QUAD_SELECT) || (CHANNEL == CH_QUAD_X4);
	assign quad_x4 = (CHANNEL == CH_QUAD_X4) || ((CHANNEL == CH_QUAD_SELECT) && i_quad_processing_select);
	// two-phase only counts with the pin source selected, as software must set up
	assign quad_on = quad_chan && i_two_phase_enable && (i_event_source_sel == SRC_PIN); // see (RL18)

	// see (RL15) see (RL16) see (RL23)
	quad_step_decode u_quad (
		.i_x4(quad_x4),
		.i_a_level(in_level),
		.i_a_rise(in_rise),
		.i_a_fall(in_fall),
		.i_b_level(out_level),
		.i_b_rise(out_rise),
		.i_b_fall(out_fall),
		.o_up(q_up),
		.o_down(q_down)
	);

	always_comb begin
		case (i_event_source_sel)
			SRC_PIN: src_event = i_count_rising_edge ? in_rise : in_fall; // see (RL13)
			SRC_TB2: src_event = i_tb2_wrap; // see (RL1)
			SRC_PREV: src_event = i_ta_wrap[prev_ch(CHANNEL)]; // see (RL2)
			SRC_NEXT: src_event = i_ta_wrap[next_ch(CHANNEL)]; // see (RL2)
			default: src_event = 1'b0;
		endcase
	end

	// stop gates every source, so the counter freezes at once
	assign ev = i_count_start_bit && (quad_on ? (q_up | q_down) : src_event); // see (RL7)
	assign up = quad_on ? q_up : (i_dir_from_pin ? out_level : i_direction_flag_reg); // see (RL3)
	assign at_limit = up ? (st_q.count == CNT_MAX) : (st_q.count == CNT_ZERO); // see (RL6)
	assign stepped = up ? 16'(st_q.count + CNT_ONE) : 16'(st_q.count - CNT_ONE);

	assign idx_ok = (CHANNEL == CH_QUAD_SELECT) && quad_on && quad_x4 && i_free_run && i_index_clear_enable; // see (RL20)
	assign idx_edge = i_index_rising_edge ? idx_rise : idx_fall;
	assign idx_apply = idx_ok && st_q.index_pend && ev; // see (RL21)
	// a stop in the run state already counts as stopped for write routing
	assign wr_load = i_count_wr && (!i_count_start_bit || (st_q.phase != ST_RUN)); // see (RL22)
	// a clear replaces the step, so it never doubles as a wrap
	assign wrap_evt = ev && at_limit && !idx_apply && !wr_load;

	always_comb begin
		st_d = st_q;
		st_d.irq = 1'b0;
		case (st_q.phase)
			ST_IDLE: begin
				if (i_count_start_bit) begin
					// an event in the start cycle is already the first one
					st_d.phase = ev ? ST_RUN : ST_ARMED; // see (RL22)
				end
			end
			ST_ARMED: begin
				if (!i_count_start_bit) begin
					st_d.phase = ST_IDLE;
				end else if (ev) begin
					st_d.phase = ST_RUN; // see (RL22)
				end
			end
			ST_RUN: begin
				if (!i_count_start_bit) begin
					st_d.phase = ST_IDLE;
				end
			end
			default: st_d.phase = ST_IDLE;
		endcase

		if (wr_load) begin
			// write beats a same-cycle first event
			st_d.count = i_count_wr_data; // see (RL10)
			st_d.reload = i_count_wr_data;
		end else begin
			if (i_count_wr) begin
				st_d.reload = i_count_wr_data; // see (RL11)
			end
			if (idx_apply) begin
				st_d.count = CNT_ZERO; // see (RL19)
			end else if (wrap_evt) begin
				st_d.irq = 1'b1; // see (RL8)
				st_d.count = i_free_run ? stepped : st_q.reload; // see (RL4) see (RL5)
			end else if (ev) begin
				st_d.count = stepped;
			end
		end

		// new index edge wins over the clear being used up
		st_d.index_pend = idx_ok && (idx_edge || (st_q.index_pend && !ev));

		if (!i_count_start_bit || !i_pulse_out_en) begin
			st_d.toggle = 1'b0; // see (RL12)
		end else if (wrap_evt) begin
			st_d.toggle = !st_q.toggle; // see (RL12)
		end
		st_d.out_oe = i_pulse_out_en && !quad_on && !i_dir_from_pin;
	end

	always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			st_q.phase <= ST_IDLE;
			st_q.count <= COUNT_RST;
			st_q.reload <= RELOAD_RST;
			st_q.irq <= 1'b0;
			st_q.toggle <= 1'b0;
			st_q.out_oe <= 1'b0;
			st_q.index_pend <= 1'b0;
		end else begin
			st_q <= st_d;
		end
	end

	assign o_count_register = st_q.count; // see (RL9)
	assign o_reload_value = st_q.reload;
	assign o_wrap_irq = st_q.irq;
	assign o_first_event_seen = (st_q.phase == ST_RUN);
	assign o_timer_out_pin = st_q.toggle;
	assign o_timer_out_pin_oe = st_q.out_oe;

	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (i_sys_rst);

	a_stop_freezes: assert property ( // see (RL7)
		!i_count_start_bit && !i_count_wr |=> o_count_register == $past(o_count_register)
	) else $error("counter moved while stopped");

	a_reload_wrap: assert property ( // see (RL4)
		wrap_evt && !i_free_run |=> o_count_register == $past(st_q.reload) && o_wrap_irq
	) else $error("reload mode wrap did not load reload value");

	a_free_wrap: assert property ( // see (RL5)
		wrap_evt && i_free_run && up |=> o_count_register == CNT_ZERO
	) else $error("free-run overflow did not wrap to zero");

	a_free_underflow: assert property ( // see (RL5)
		wrap_evt && i_free_run && !up |=> o_count_register == CNT_MAX
	) else $error("free-run underflow did not wrap to all ones");

	a_irq_on_wrap: assert property ( // see (RL8)
		o_wrap_irq |-> $past(ev) && $past(at_limit) && !$past(idx_apply)
	) else $error("interrupt without an overflow or underflow");

	a_write_both: assert property ( // see (RL10)
		i_count_wr && !(o_first_event_seen && i_count_start_bit) |=>
			o_count_register == $past(i_count_wr_data) && o_reload_value == o_count_register
	) else $error("early write did not load counter and reload");

	a_write_reload_only: assert property ( // see (RL11)
		i_count_wr && o_first_event_seen && i_count_start_bit && !ev |=>
			o_reload_value == $past(i_count_wr_data) && $stable(o_count_register)
	) else $error("running write touched the counter");

	a_out_low_stopped: assert property ( // see (RL12)
		!i_count_start_bit |=> !o_timer_out_pin
	) else $error("pulse output not low while stopped");

	a_first_event: assert property ( // see (RL22)
		i_count_start_bit && ev && !o_first_event_seen |=> o_first_event_seen
	) else $error("first event did not set the counting flag");

	a_index_clear: assert property ( // see (RL21)
		idx_apply && !wr_load |=> o_count_register == CNT_ZERO && (!st_q.index_pend || $past(idx_edge))
	) else $error("index clear missed at count timing");

	a_single_step: assert property ( // see (RL23)
		ev && up && !at_limit && !idx_apply && !wr_load |=> o_count_register == 16'($past(o_count_register) + CNT_ONE)
	) else $error("count did not advance by exactly one");

	a_toggle_on_wrap: assert property ( // see (RL12)
		wrap_evt && i_pulse_out_en && i_count_start_bit |=> o_timer_out_pin != $past(o_timer_out_pin)
	) else $error("pulse output did not invert on wrap");
endmodule // evt_counter_channel
`default_nettype wire

// ---- tb/quad_encoder_model.sv ----
// two-phase encoder with index output that stands on the channel's pins
`timescale 1ns/1ps
`default_nettype none
module quad_encoder_model (
	input wire logic i_clk,
	output logic o_phase_a,
	output logic o_phase_b,
	output var logic o_index
);
	logic [1:0] ph = 2'h0;
	initial o_index = 1'b0;
	// gray order (a, b) 00, 01, 11, 10: forward sees a rising while b is high
	always_comb begin
		o_phase_a = ph[1];
		o_phase_b = ph[1] ^ ph[0];
	end
	// one transition per call, so both pins never move in the same sample
	task automatic step(input logic fwd, input int gap);
		@(negedge i_clk);
		ph = fwd ? ph + 2'h1 : ph - 2'h1;
		repeat (gap) @(negedge i_clk);
	endtask
	// index held for several cycles, longer than one count clock
	task automatic index_pulse();
		@(negedge i_clk);
		o_index = 1'b1;
		repeat (4) @(negedge i_clk);
		o_index = 1'b0;
		repeat (4) @(negedge i_clk);
	endtask
endmodule // quad_encoder_model
`default_nettype wire

// ---- tb/tb_evt_counter_channel.sv ----
// self-checking bench for the event counter channel
`timescale 1ns/1ps
`default_nettype none
module tb_evt_counter_channel;
	import evt_counter_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic start = 1'b0, redge = 1'b1, dirpin = 1'b0, dflag = 1'b1, frun = 1'b0, pen = 1'b0;
	logic twop = 1'b0, qsel = 1'b0, zen = 1'b0, zredge = 1'b1, tb2 = 1'b0, wr = 1'b0, up;
	logic [1:0] src = SRC_PREV;
	logic [4:0] taw = 5'h00;
	logic [15:0] wdata = 16'h0000, n;
	logic pa, pb, pz, b_wire, out_q, out_oe, irq, first;
	logic [15:0] cnt, rld, cnt2, cnt4;
	int failures = 0, n_compared = 0, irqs = 0, i0, e, k, m;
	int seed = 32'hd42549fd;
	always #25 clk = ~clk;
	always @(posedge clk) begin
		if (irq === 1'b1) irqs <= irqs + 1;
	end
	// the out pin is shared: the channel wins while it drives
	assign b_wire = (out_oe === 1'b1) ? out_q : pb;
	quad_encoder_model enc (.i_clk(clk), .o_phase_a(pa), .o_phase_b(pb), .o_index(pz));
	evt_counter_channel #(.CHANNEL(CH_QUAD_SELECT)) uut (.i_core_clk(clk), .i_sys_rst(rst),
		.i_timer_input_pin(pa), .i_timer_out_pin(b_wire), .i_index_pin(pz), .i_count_start_bit(start),
		.i_event_source_sel(src), .i_count_rising_edge(redge), .i_dir_from_pin(dirpin),
		.i_direction_flag_reg(dflag), .i_free_run(frun), .i_pulse_out_en(pen), .i_two_phase_enable(twop),
		.i_quad_processing_select(qsel), .i_index_clear_enable(zen), .i_index_rising_edge(zredge),
		.i_tb2_wrap(tb2), .i_ta_wrap(taw), .i_count_wr(wr), .i_count_wr_data(wdata),
		.o_count_register(cnt), .o_reload_value(rld), .o_wrap_irq(irq), .o_first_event_seen(first),
		.o_timer_out_pin(out_q), .o_timer_out_pin_oe(out_oe));
	// fixed-mode two-phase channels share every input with the selectable one
	evt_counter_channel #(.CHANNEL(CH_QUAD_NORMAL)) uut_ch2 (.i_core_clk(clk), .i_sys_rst(rst),
		.i_timer_input_pin(pa), .i_timer_out_pin(b_wire), .i_index_pin(pz), .i_count_start_bit(start),
		.i_event_source_sel(src), .i_count_rising_edge(redge), .i_dir_from_pin(dirpin),
		.i_direction_flag_reg(dflag), .i_free_run(frun), .i_pulse_out_en(pen), .i_two_phase_enable(twop),
		.i_quad_processing_select(qsel), .i_index_clear_enable(zen), .i_index_rising_edge(zredge),
		.i_tb2_wrap(tb2), .i_ta_wrap(taw), .i_count_wr(wr), .i_count_wr_data(wdata),
		.o_count_register(cnt2), .o_reload_value(), .o_wrap_irq(), .o_first_event_seen(),
		.o_timer_out_pin(), .o_timer_out_pin_oe());
	evt_counter_channel #(.CHANNEL(CH_QUAD_X4)) uut_ch4 (.i_core_clk(clk), .i_sys_rst(rst),
		.i_timer_input_pin(pa), .i_timer_out_pin(b_wire), .i_index_pin(pz), .i_count_start_bit(start),
		.i_event_source_sel(src), .i_count_rising_edge(redge), .i_dir_from_pin(dirpin),
		.i_direction_flag_reg(dflag), .i_free_run(frun), .i_pulse_out_en(pen), .i_two_phase_enable(twop),
		.i_quad_processing_select(qsel), .i_index_clear_enable(zen), .i_index_rising_edge(zredge),
		.i_tb2_wrap(tb2), .i_ta_wrap(taw), .i_count_wr(wr), .i_count_wr_data(wdata),
		.o_count_register(cnt4), .o_reload_value(), .o_wrap_irq(), .o_first_event_seen(),
		.o_timer_out_pin(), .o_timer_out_pin_oe());
	function automatic int period(input logic u, input logic [15:0] v);
		return u ? 32'h10000 - v : v + 1;
	endfunction
	task automatic chk16(input string nm, input logic [15:0] x, input logic [15:0] g);
		n_compared++;
		if (g !== x) begin
			failures++;
			$display("unexpected %s expected %h seen %h", nm, x, g);
		end
	endtask
	task automatic chkb(input string nm, input logic x, input logic g);
		n_compared++;
		if (g !== x) begin
			failures++;
			$display("unexpected %s expected %b seen %b", nm, x, g);
		end
	endtask
	task automatic cyc(input int c);
		repeat (c) @(negedge clk);
	endtask
	// idx 0..4 neighbour wrap lines, 5 the b2 line; held high for c events
	task automatic ev(input int idx, input int c);
		cyc(1);
		if (idx == 5) tb2 = 1'b1;
		else taw[idx] = 1'b1;
		cyc(c);
		tb2 = 1'b0;
		taw = 5'h00;
		cyc(3);
	endtask
	task automatic wcount(input logic [15:0] d);
		wdata = d;
		wr = 1'b1;
		cyc(1);
		wr = 1'b0;
		cyc(1);
	endtask
	task automatic restart(input logic [15:0] d);
		start = 1'b0;
		cyc(2);
		wcount(d);
		start = 1'b1;
		cyc(2);
	endtask
	task automatic finish_test();
		$display("compared %0d mismatches %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	initial begin
		repeat (50000) @(posedge clk);
		failures++;
		finish_test();
	end
	initial begin
		repeat (6) @(posedge clk);
		cyc(1);
		rst = 1'b0;
		cyc(1);
		chk16("count", COUNT_RST, cnt);
		chk16("reload", RELOAD_RST, rld);
		wcount(16'h1234);
		chk16("count", 16'h1234, cnt);
		chk16("reload", 16'h1234, rld);
		start = 1'b1;
		cyc(2);
		wcount(16'h0100);
		chk16("count", 16'h0100, cnt);
		ev(4, 1);
		chk16("count", 16'h0100, cnt);
		chkb("first", 1'b0, first);
		ev(2, 1);
		chk16("count", 16'h0101, cnt);
		chkb("first", 1'b1, first);
		src = SRC_NEXT;
		ev(4, 2);
		ev(2, 1);
		chk16("count", 16'h0103, cnt);
		src = SRC_TB2;
		ev(5, 1);
		chk16("count", 16'h0104, cnt);
		wcount(16'h0200);
		chk16("count", 16'h0104, cnt);
		chk16("reload", 16'h0200, rld);
		start = 1'b0;
		cyc(2);
		ev(5, 2);
		chk16("count", 16'h0104, cnt);
		chkb("first", 1'b0, first);
		$display("test routing done");
		pen = 1'b1;
		for (k = 0; k < 4; k++) begin
			up = k[0];
			frun = k[1];
			dflag = up;
			n = up ? (16'hFFF0 | 16'($random(seed) & 15)) : 16'($random(seed) & 15);
			restart(n);
			i0 = irqs;
			e = period(up, n);
			if (e > 1) ev(5, e - 1);
			chk16("irqs", 16'h0000, 16'(irqs - i0));
			chkb("out", 1'b0, out_q);
			chkb("oe", 1'b1, out_oe);
			ev(5, 1);
			chk16("irqs", 16'h0001, 16'(irqs - i0));
			chkb("out", 1'b1, out_q);
			chk16("count", frun ? (up ? CNT_ZERO : CNT_MAX) : n, cnt);
			start = 1'b0;
			cyc(2);
			chkb("out", 1'b0, out_q);
		end
		$display("test wrap done");
		pen = 1'b0;
		frun = 1'b0;
		dirpin = 1'b1;
		restart(16'h0050);
		enc.step(1'b1, 5);
		ev(5, 2);
		chk16("count", 16'h0052, cnt);
		chkb("oe", 1'b0, out_oe);
		enc.step(1'b1, 5);
		enc.step(1'b1, 5);
		ev(5, 3);
		chk16("count", 16'h004F, cnt);
		enc.step(1'b1, 5);
		dirpin = 1'b0;
		dflag = 1'b1;
		src = SRC_PIN;
		restart(16'h0000);
		for (k = 0; k < 12; k++) begin
			if (k == 4) redge = 1'b0;
			if (k == 8) src = SRC_TB2;
			enc.step(1'b1, 5);
		end
		chk16("count", 16'h0002, cnt);
		$display("test pin source done");
		twop = 1'b1;
		src = SRC_PIN;
		frun = 1'b1;
		for (k = 0; k < 2; k++) begin
			qsel = ~k[0];
			m = 1 + ($random(seed) & 3);
			restart(16'h8000);
			repeat (4 * m) enc.step(1'b1, 4 + ($random(seed) & 3));
			chk16("count", 16'(32'h8000 + (qsel ? 4 * m : m)), cnt);
			chk16("count2", 16'(32'h8000 + m), cnt2);
			chk16("count4", 16'(32'h8000 + 4 * m), cnt4);
			repeat (4 * m) enc.step(1'b0, 4 + ($random(seed) & 3));
			chk16("count", 16'h8000, cnt);
		end
		$display("test two phase done");
		qsel = 1'b1;
		zen = 1'b1;
		restart(16'h0000);
		repeat (3) enc.step(1'b1, 5);
		enc.index_pulse();
		chk16("count", 16'h0003, cnt);
		enc.step(1'b1, 5);
		chk16("count", 16'h0000, cnt);
		enc.step(1'b1, 5);
		chk16("count", 16'h0001, cnt);
		zen = 1'b0;
		enc.index_pulse();
		enc.step(1'b1, 5);
		chk16("count", 16'h0002, cnt);
		zen = 1'b1;
		zredge = 1'b0;
		enc.index_pulse();
		enc.step(1'b1, 5);
		chk16("count", 16'h0000, cnt);
		$display("test index done");
		finish_test();
	end
endmodule // tb_evt_counter_channel
`default_nettype wire
